// ===== include/rcp_defs.svh
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH
// ****************************************
// Register byte addresses on the APB.
// ****************************************
`define RCP_ADDR_REQ 8'h00
`define RCP_ADDR_CUR 8'h04
`define RCP_ADDR_STAT 8'h08
`define RCP_ADDR_CFG 8'h0c
`define RCP_ADDR_WAIT 8'h10
`define RCP_ADDR_INFO 8'h14
`define RCP_ADDR_PDIR_LO 8'h40
`define RCP_ADDR_PDIR_HI 8'h8c
// ****************************************
// Field positions.
// ****************************************
`define RCP_REQ_SRC_LSB 0
`define RCP_REQ_MODE_LSB 16
`define RCP_STAT_ERR_BIT 0
`define RCP_STAT_BUSY_BIT 1
// ****************************************
// Encodings.
// ****************************************
`define RCP_VER_A 2'h1
`define RCP_VER_B 2'h2
`define RCP_VER_C 2'h3
`define RCP_SRC_FAST 16'h0100
`define RCP_SRC_MAIN 16'h0200
`define RCP_SRC_SUB 16'h0300
`define RCP_SRC_PLL 16'h0400
`define RCP_MODE_HIGH 8'h00
`define RCP_MODE_MID_1A 8'h02
`define RCP_MODE_MID_1B 8'h03
`define RCP_MODE_MID_2A 8'h04
`define RCP_MODE_MID_2B 8'h05
`define RCP_MODE_LOW_1 8'h06
`define RCP_MODE_LOW_2 8'h07
`define RCP_SUB_DRIVE_LOW 8'h02
`define RCP_SUB_DRIVE_STD 8'h0c
`define RCP_FREQ_50 2'h3
`define RCP_FAST_WAIT_50 8'h03
`define RCP_FAST_WAIT_OTHER 8'h02
`define RCP_DIV_PLL 32'h2182_1211
`define RCP_DIV_FAST 32'h1081_1110
`define RCP_DIV_OTHER 32'h0080_1010
`define RCP_STOP_ON 1'b1
`define RCP_STOP_OFF 1'b0
// ****************************************
// Reset values and timing.
// ****************************************
`define RCP_RST_SRC 16'h0000
`define RCP_RST_MODE 8'h00
`define RCP_RST_VER 2'h1
`define RCP_TICK_DIV 5'h1f
`define RCP_TICK_NS 232727
`define RCP_FAST_MIN_WAIT_NS 350000
`define RCP_FAST_MIN_TICKS ((`RCP_FAST_MIN_WAIT_NS + `RCP_TICK_NS - 1) / `RCP_TICK_NS)
// ****************************************
// Direction presets, port P0 in the low byte up to port PL at the top.
// ****************************************
`define RCP_PDIR_145 160'h0
`define RCP_PDIR_100 160'h03_3c_20_00_20_00_00_00_00_00_0f_cf_ff_ff_40_00_00_00_00_07
`define RCP_PDIR_80 160'h00_00_08_00_00_c0_f8_03_00_80_00_00_00_00_0f_00_08_3c_00_00
`define RCP_PDIR_64 160'h00_00_0a_00_00_c0_ff_03_14_a4_00_00_00_00_0f_a0_18_3f_0c_80
`define RCP_PDIR_48 160'h00_00_0a_00_00_e1_ff_0f_d4_a5_00_00_00_00_3f_b8_1c_3f_0c_a8
`endif

// ===== include/rcp_pkg.sv
package rcp_pkg;
    // Package size selector for the direction presets.
    typedef enum logic [2:0] {
        RCP_PKG_145 = 3'b000,
        RCP_PKG_100 = 3'b001,
        RCP_PKG_80 = 3'b010,
        RCP_PKG_64 = 3'b011,
        RCP_PKG_48 = 3'b100
    } rcp_pkg_e;
    // Static configuration that software writes into the CFG register.
    typedef struct packed {
        logic [2:0] mstop;
        rcp_pkg_e pkg;
        logic sub_std;
        logic [1:0] freq;
        logic fast_en;
        logic pll_en;
        logic [1:0] ver;
    } rcp_cfg_s;
    // A clock source and power mode pair.
    typedef struct packed {
        logic [7:0] mode;
        logic [15:0] src;
    } rcp_sel_s;
endpackage

// ===== core/rcp_preset_rom.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.svh"
module rcp_preset_rom (
    input wire rcp_pkg::rcp_pkg_e pkg,
    input wire logic [4:0] port_idx,
    output logic [7:0] dir_preset
);
    import rcp_pkg::*;
    // ****************************************
    // Table selection.
    // ****************************************
    // Whole table for the selected package; unknown codes fall back to all inputs.
    wire logic [159:0] table_w;
    assign table_w = (pkg == RCP_PKG_100) ? `RCP_PDIR_100 :
                     (pkg == RCP_PKG_80) ? `RCP_PDIR_80 :
                     (pkg == RCP_PKG_64) ? `RCP_PDIR_64 :
                     (pkg == RCP_PKG_48) ? `RCP_PDIR_48 : `RCP_PDIR_145;
    // Indexes past the last port read as zero so no bit is forced by mistake.
    assign dir_preset = (port_idx < 5'd20) ? table_w[{port_idx, 3'b000} +: 8] : 8'h00;
endmodule
`default_nettype wire

// ===== core/rcp_top.sv
// Summary of operation
// - Version A refuses main clock as source
// - Middle modes 2A, 2B legal on version B
// - Low mode 1 refused while PLL enabled
// - Low mode 2 refused with PLL or fast osc
// - Power mode codes 00h, 02h to 07h
// - Source codes 0100h, 0200h, 0300h, 0400h
// - Sub drive 02h low load, 0Ch standard
// - Module stop: one stops, zero runs
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.svh"
module rcp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_onchip_osc,
    output logic [15:0] sys_clk_sel,
    output logic [7:0] power_mode,
    output logic [31:0] sys_clk_divider_word,
    output logic [7:0] fast_osc_wait_value,
    output logic [7:0] sub_drive,
    output logic [2:0] module_stop,
    output logic pll_osc_en,
    output logic fast_onchip_osc_en,
    output logic cfg_error,
    output logic wait_busy
);
    import rcp_pkg::*;

    // ****************************************
    // Functions.
    // ****************************************
    // True when a source and mode pair may be applied under the given configuration.
    function automatic logic sel_legal(input rcp_sel_s s, input rcp_cfg_s c);
        logic src_ok;
        logic mode_ok;
        src_ok = (s.src == `RCP_SRC_FAST) || (s.src == `RCP_SRC_SUB) ||
                 (s.src == `RCP_SRC_PLL) ||
                 ((s.src == `RCP_SRC_MAIN) && (c.ver != `RCP_VER_A));
        mode_ok = (s.mode == `RCP_MODE_HIGH) || (s.mode == `RCP_MODE_MID_1A) ||
                  (s.mode == `RCP_MODE_MID_1B) ||
                  (((s.mode == `RCP_MODE_MID_2A) || (s.mode == `RCP_MODE_MID_2B)) &&
                   (c.ver == `RCP_VER_B)) ||
                  ((s.mode == `RCP_MODE_LOW_1) && !c.pll_en) ||
                  ((s.mode == `RCP_MODE_LOW_2) && !c.pll_en && !c.fast_en);
        return src_ok && mode_ok;
    endfunction

    // Divider word that goes with a clock source.
    function automatic logic [31:0] div_for(input logic [15:0] src);
        return (src == `RCP_SRC_PLL) ? `RCP_DIV_PLL :
               (src == `RCP_SRC_FAST) ? `RCP_DIV_FAST : `RCP_DIV_OTHER;
    endfunction

    // ****************************************
    // State.
    // ****************************************
    rcp_cfg_s cfg_q; // Software configuration.
    rcp_sel_s cur_q; // Source and mode in force.
    logic err_q; // Sticky refusal flag.
    logic [15:0] wait_cnt_q; // Remaining wait ticks.
    logic [4:0] pre_q; // Slow-oscillator edge prescaler.
    logic [2:0] osc_sync_q; // Two-stage synchroniser plus edge history.
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic busy_q; // Registered copy of the counter-nonzero test.
    logic [31:0] div_q;
    logic [7:0] fwait_q;
    logic [7:0] sdrv_q;

    // ****************************************
    // Bus decode.
    // ****************************************
    // The setup phase prepares the answer; the access phase commits writes.
    wire logic setup_w = psel && !penable;
    wire logic commit_w = psel && penable && pready_q;
    wire logic wr_w = commit_w && pwrite;
    wire logic hit_req = (paddr == `RCP_ADDR_REQ);
    wire logic hit_cur = (paddr == `RCP_ADDR_CUR);
    wire logic hit_stat = (paddr == `RCP_ADDR_STAT);
    wire logic hit_cfg = (paddr == `RCP_ADDR_CFG);
    wire logic hit_wait = (paddr == `RCP_ADDR_WAIT);
    wire logic hit_info = (paddr == `RCP_ADDR_INFO);
    wire logic hit_pdir = (paddr >= `RCP_ADDR_PDIR_LO) && (paddr <= `RCP_ADDR_PDIR_HI) &&
                          (paddr[1:0] == 2'b00);
    wire logic mapped_w = hit_req || hit_cur || hit_stat || hit_cfg || hit_wait ||
                          hit_info || hit_pdir;
    // Preset tables are read-only; writing them is a slave error.
    wire logic bad_w = !mapped_w || (pwrite && (hit_cur || hit_info || hit_pdir));

    // Port index from the preset window address.
    wire logic [7:0] pdir_off_w = paddr - `RCP_ADDR_PDIR_LO;
    wire logic [7:0] pdir_val_w;

    // Direction preset lookup for the port being addressed.
    rcp_preset_rom u_rom (
        .pkg(cfg_q.pkg),
        .port_idx(pdir_off_w[6:2]),
        .dir_preset(pdir_val_w)
    );

    // ****************************************
    // Request check.
    // ****************************************
    wire rcp_sel_s req_w = pwdata[23:0];
    wire logic req_wr_w = wr_w && hit_req;
    wire logic req_ok_w = sel_legal(req_w, cfg_q);
    // Error sets on a refused request; a same-cycle clear loses to the set.
    wire logic err_clr_w = wr_w && hit_stat && pwdata[`RCP_STAT_ERR_BIT];
    wire logic err_d = (req_wr_w && !req_ok_w) || (err_q && !err_clr_w);

    // ****************************************
    // Wait timer.
    // ****************************************
    // One tick per 32 rising edges of the synchronised slow oscillator.
    wire logic osc_rise_w = osc_sync_q[1] && !osc_sync_q[2];
    wire logic tick_w = osc_rise_w && (pre_q == `RCP_TICK_DIV);
    wire logic [15:0] wait_d = (wr_w && hit_wait) ? pwdata[15:0] :
                               (tick_w && (wait_cnt_q != 16'h0000)) ?
                               wait_cnt_q - 16'h0001 : wait_cnt_q;

    // ****************************************
    // Read mux.
    // ****************************************
    wire logic [31:0] rd_w =
        hit_req ? {8'h00, cur_q} :
        hit_cur ? {8'h00, cur_q} :
        hit_stat ? {30'h0, (wait_cnt_q != 16'h0000), err_q} :
        hit_cfg ? {19'h0, cfg_q} :
        hit_wait ? {16'h0, wait_cnt_q} :
        hit_info ? {fwait_q, sdrv_q, 16'h0000} :
        hit_pdir ? {24'h0, pdir_val_w} : 32'h0000_0000;

    // ****************************************
    // Bus answer registers.
    // ****************************************
    // Answer is ready in the first access cycle, so no wait states occur.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_w;
            pslverr_q <= setup_w && bad_w;
            prdata_q <= (setup_w && !pwrite) ? rd_w : 32'h0000_0000;
        end
    end

    // ****************************************
    // Configuration and selection.
    // ****************************************
    // A refused request leaves the source and mode untouched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '{mstop: {3{`RCP_STOP_OFF}}, pkg: RCP_PKG_145, sub_std: 1'b0,
                       freq: 2'h0, fast_en: 1'b0, pll_en: 1'b0, ver: `RCP_RST_VER};
            cur_q <= '{mode: `RCP_RST_MODE, src: `RCP_RST_SRC};
            err_q <= 1'b0;
        end else begin
            if (wr_w && hit_cfg) begin
                cfg_q <= pwdata[12:0];
            end
            if (req_wr_w && req_ok_w) begin
                cur_q <= req_w;
            end
            err_q <= err_d;
        end
    end

    // ****************************************
    // Derived settings.
    // ****************************************
    // Registered so each output leaves straight from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= `RCP_DIV_OTHER;
            fwait_q <= `RCP_FAST_WAIT_OTHER;
            sdrv_q <= `RCP_SUB_DRIVE_LOW;
        end else begin
            div_q <= div_for(cur_q.src);
            fwait_q <= (cfg_q.freq == `RCP_FREQ_50) ? `RCP_FAST_WAIT_50 :
                       `RCP_FAST_WAIT_OTHER;
            sdrv_q <= cfg_q.sub_std ? `RCP_SUB_DRIVE_STD : `RCP_SUB_DRIVE_LOW;
        end
    end

    // ****************************************
    // Slow oscillator synchroniser and timer.
    // ****************************************
    // The pin is asynchronous; logic looks only at the second stage and at the edge history behind it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync_q <= 3'b000;
            pre_q <= 5'h00;
            wait_cnt_q <= 16'h0000;
            busy_q <= 1'b0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], slow_onchip_osc};
            pre_q <= osc_rise_w ? pre_q + 5'h01 : pre_q;
            wait_cnt_q <= wait_d;
            // Taken from the next count so the busy pin leaves a flip-flop in step with it.
            busy_q <= (wait_d != 16'h0000);
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sys_clk_sel = cur_q.src;
    assign power_mode = cur_q.mode;
    assign sys_clk_divider_word = div_q;
    assign fast_osc_wait_value = fwait_q;
    assign sub_drive = sdrv_q;
    assign module_stop = cfg_q.mstop;
    assign pll_osc_en = cfg_q.pll_en;
    assign fast_onchip_osc_en = cfg_q.fast_en;
    assign cfg_error = err_q;
    assign wait_busy = busy_q;
endmodule
`default_nettype wire

// ===== verification/rcp_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.svh"
// ****************************************
// Port-level checker for the clock and power-mode selector.
// ****************************************
module rcp_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [15:0] sys_clk_sel,
    input wire logic [7:0] power_mode,
    input wire logic [31:0] sys_clk_divider_word,
    input wire logic [7:0] fast_osc_wait_value,
    input wire logic [7:0] sub_drive,
    input wire logic cfg_error
);
    // A write counts only at the edge where the slave shows ready.
    wire logic wr_ok = psel && penable && pready && pwrite;
    wire logic wr_req = wr_ok && paddr == `RCP_ADDR_REQ;
    wire logic [15:0] rq_src = pwdata[15:0];
    wire logic [7:0] rq_mode = pwdata[23:16];
    // Shadow of the configuration word, since the checker cannot read it back.
    logic [12:0] cfg_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 13'h0001;
        end else if (wr_ok && paddr == `RCP_ADDR_CFG) begin
            cfg_q <= pwdata[12:0];
        end
    end
    wire logic ver_a = cfg_q[1:0] == `RCP_VER_A;
    wire logic ver_b = cfg_q[1:0] == `RCP_VER_B;
    wire logic src_ok = rq_src == `RCP_SRC_FAST || rq_src == `RCP_SRC_SUB ||
        rq_src == `RCP_SRC_PLL || (rq_src == `RCP_SRC_MAIN && !ver_a);
    wire logic mode_ok = rq_mode == `RCP_MODE_HIGH || rq_mode == `RCP_MODE_MID_1A ||
        rq_mode == `RCP_MODE_MID_1B || (rq_mode inside {8'h04, 8'h05} && ver_b) ||
        (rq_mode == `RCP_MODE_LOW_1 && !cfg_q[2]) ||
        (rq_mode == `RCP_MODE_LOW_2 && !cfg_q[2] && !cfg_q[3]);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_main_refused: assert property (wr_req && rq_src == `RCP_SRC_MAIN && ver_a
        |=> cfg_error && $stable(sys_clk_sel)) else $error("main source taken on version A");
    a_mid2_refused: assert property (wr_req && rq_mode inside {8'h04, 8'h05} && !ver_b
        |=> cfg_error && $stable(power_mode)) else $error("middle mode 2 taken off version B");
    a_low1_refused: assert property (wr_req && rq_mode == `RCP_MODE_LOW_1 && cfg_q[2]
        |=> cfg_error && $stable(power_mode)) else $error("low mode 1 taken with pll on");
    a_low2_refused: assert property (wr_req && rq_mode == `RCP_MODE_LOW_2
        && |cfg_q[3:2] |=> cfg_error && $stable(power_mode))
        else $error("low mode 2 taken with osc on");
    a_legal_taken: assert property (wr_req && src_ok && mode_ok
        |=> power_mode == $past(rq_mode) && sys_clk_sel == $past(rq_src))
        else $error("legal request not applied");
    a_div_word: assert property (1'b1 |-> sys_clk_divider_word ==
        ($past(sys_clk_sel) == `RCP_SRC_PLL ? `RCP_DIV_PLL : $past(sys_clk_sel) ==
        `RCP_SRC_FAST ? `RCP_DIV_FAST : `RCP_DIV_OTHER)) else $error("divider word wrong");
    a_fast_wait: assert property (1'b1 |-> fast_osc_wait_value ==
        ($past(cfg_q[5:4]) == `RCP_FREQ_50 ? `RCP_FAST_WAIT_50 : `RCP_FAST_WAIT_OTHER))
        else $error("fast wait value wrong");
    a_sub_drive: assert property (1'b1 |-> sub_drive ==
        ($past(cfg_q[6]) ? `RCP_SUB_DRIVE_STD : `RCP_SUB_DRIVE_LOW))
        else $error("drive code wrong");
endmodule
bind rcp_top rcp_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .sys_clk_sel(sys_clk_sel), .power_mode(power_mode), .sub_drive(sub_drive),
    .sys_clk_divider_word(sys_clk_divider_word), .fast_osc_wait_value(fast_osc_wait_value),
    .cfg_error(cfg_error));
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcp_defs.svh"
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow_osc = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata, div_w;
    logic pready, pslverr, pll_en, fast_en, cfg_error, wait_busy;
    logic [15:0] sel;
    logic [7:0] mode, fwait, sdrv;
    logic [2:0] mstop;
    int n_fail = 0, cmp_count = 0, m_src = 0, m_mode = 0, m_err = 0, cyc, ok;
    // Bus cycles per wait tick: 32 slow edges of 98 ns each.
    localparam int TICK_CYC = 32 * 98 / 25;
    // Expected direction presets per package code, port P0 in the low byte.
    localparam logic [159:0] PDIR [5] = '{160'h0,
        160'h033c2000200000000000_0fcfffff400000000007,
        160'h0000080000c0f8030080_000000000f00083c0000,
        160'h00000a0000c0ff0314a4_000000000fa0183f0c80,
        160'h00000a0000e1ff0fd4a5_000000003fb81c3f0ca8};
    always #12.5 pclk = ~pclk;
    // The slow oscillator runs free and unrelated in phase to the bus clock.
    always #49 slow_osc = ~slow_osc;
    rcp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_onchip_osc(slow_osc), .sys_clk_sel(sel), .power_mode(mode),
        .sys_clk_divider_word(div_w), .fast_osc_wait_value(fwait), .sub_drive(sdrv),
        .module_stop(mstop), .pll_osc_en(pll_en), .fast_onchip_osc_en(fast_en),
        .cfg_error(cfg_error), .wait_busy(wait_busy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until ready is seen at an edge.
    // Wait states are whatever the slave inserts; only the watchdog ends a hang.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic int legal(int v, int p, int f, int s, int m);
        return s >= 1 && s <= 4 && !(s == 2 && v == 1) && (m == 0 || m == 2 || m == 3 ||
            (m inside {4, 5} && v == 2) || (m == 6 && !p) || (m == 7 && !p && !f));
    endfunction
    // Compares every static output with the model built from configuration word c.
    task automatic ports(input int c);
        logic [31:0] exp_div;
        exp_div = m_src == 'h400 ? 32'h21821211 : m_src == 'h100 ? 32'h10811110 : 32'h00801010;
        chk(32'(sel), m_src);
        chk(32'(mode), m_mode);
        chk(div_w, exp_div);
        chk(32'(fwait), c[5:4] == 3 ? 32'h3 : 32'h2);
        chk(32'(sdrv), c[6] ? 32'hc : 32'h2);
        chk(32'(mstop), 32'(c[12:10]));
        chk(32'({fast_en, pll_en}), 32'(c[3:2]));
    endtask
    task automatic end_of_test;
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(63));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        ports(1);
        apb(0, 8'h30, 0);
        chk(rd, 0);
        chk(32'(err), 1);
        apb(1, `RCP_ADDR_INFO, 32'hffffffff);
        chk(32'(err), 1);
        $display("test refusals done");
        for (int p = 0; p < 5; p++) begin
            apb(1, `RCP_ADDR_CFG, 32'((p << 7) | 1));
            for (int i = 0; i < 20; i++) begin
                apb(0, 8'(8'h40 + 4 * i), 0);
                chk(rd, 32'(PDIR[p][8*i+:8]));
            end
        end
        $display("test presets done");
        for (int k = 0; k < 80; k++) begin
            int v, c, s, m;
            v = 1 + $urandom % 3;
            c = ($urandom & 'h1c7c) | v;
            s = $urandom % 6;
            m = $urandom % 9;
            apb(1, `RCP_ADDR_CFG, c);
            apb(1, `RCP_ADDR_REQ, 32'((m << 16) | (s << 8)));
            if (legal(v, c[2], c[3], s, m)) begin
                m_src = s << 8;
                m_mode = m;
            end else m_err = 1;
            apb(0, `RCP_ADDR_CUR, 0);
            chk(rd, m_mode << 16 | m_src);
            apb(0, `RCP_ADDR_STAT, 0);
            chk(rd, m_err);
            chk(32'(cfg_error), m_err);
            ports(c);
            if (k % 3 == 0) begin
                apb(1, `RCP_ADDR_STAT, 1);
                m_err = 0;
            end
        end
        $display("test legality done");
        // Start-up order: stop the modules, read a preset, start the fast osc, wait, switch.
        apb(1, `RCP_ADDR_CFG, 32'h0000_1c82);
        apb(0, `RCP_ADDR_PDIR_LO, 0);
        // Later byte writes to port P0 must keep this mask of outputs.
        chk(rd, 32'h0000_0007);
        apb(1, `RCP_ADDR_CFG, 32'h0000_1cba);
        // One tick more than the minimum, since the first tick may come early.
        apb(1, `RCP_ADDR_WAIT, `RCP_FAST_MIN_TICKS + 1);
        apb(0, `RCP_ADDR_STAT, 0);
        chk(32'(rd[1]), 1);
        cyc = 0;
        while (wait_busy === 1'b1 && cyc < 1000) begin
            @(posedge pclk);
            cyc++;
        end
        ok = cyc > `RCP_FAST_MIN_TICKS * TICK_CYC - 6;
        ok = ok && cyc < (`RCP_FAST_MIN_TICKS + 1) * TICK_CYC + 6;
        chk(32'(ok), 1);
        apb(1, `RCP_ADDR_REQ, 32'(`RCP_SRC_FAST));
        m_src = 'h100;
        m_mode = 0;
        apb(0, `RCP_ADDR_CUR, 0);
        chk(rd, m_mode << 16 | m_src);
        ports('h1cba);
        $display("test wait done");
        end_of_test;
    end
    initial begin
        #(25 * 40000);
        n_fail++;
        end_of_test;
    end
endmodule
`default_nettype wire
